// [core/dcp_pkg.sv]
// Constants shared by the potentiometer serial register access logic.
package dcp_pkg;
  // Register map.
  localparam logic [4:0] ADDR_INITIAL  = 5'h00;
  localparam logic [4:0] ADDR_RESERVED = 5'h0F;
  localparam logic [4:0] ADDR_ACCESS   = 5'h10;
  localparam int         NV_COUNT      = 16;
  // Access control register field positions.
  localparam int VSEL_BIT = 7;
  localparam int SHDN_BIT = 6;
  localparam int PROG_BIT = 5;
  // Reset values.
  localparam logic [7:0] WIPER_RESET   = 8'h80;
  localparam logic [7:0] INITIAL_RESET = 8'h80;
  localparam logic [7:0] NV_RESET      = 8'h00;
  localparam logic       VSEL_RESET    = 1'b0;
  localparam logic       SHDN_RESET    = 1'b1;
  // Timing.
  localparam int CLK_FREQ_HZ       = 100_000_000;
  localparam int NV_WRITE_TIME_MS  = 20;
  localparam int NV_WRITE_CYCLES   = NV_WRITE_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int PROG_CNT_W        = 21;
  // Write record buffer.
  localparam int REC_W      = 13;
  localparam int FIFO_DEPTH = 32;
  // Byte counters.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

// [core/dcp_i2c.sv]
// Serial slave, write record buffer and register file of the potentiometer.
`timescale 1ns/10ps

module dcp_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  // Fill side.
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side.
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign in_ready_out  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out  = mem_r[rd_r];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_comb begin
    wr_nxt  = push ? AW'(wr_r + 1'b1) : wr_r;
    rd_nxt  = pop ? AW'(rd_r + 1'b1) : rd_r;
    cnt_nxt = (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_r[wr_r] <= in_data_in;
    end
  end
endmodule // dcp_fifo

module dcp_i2c #(
  parameter int         NV_WRITE_CYCLES = dcp_pkg::NV_WRITE_CYCLES,
  // Slave address high bits; the value is arbitrary.
  parameter logic [4:0] ID_PREFIX       = 5'h16
) (
  // Clock and reset.
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  // Serial bus pins.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  // Address select straps.
  input  wire logic       address_select_hi_in,
  input  wire logic       address_select_lo_in,
  // Potentiometer control.
  output logic [7:0]      wiper_out,
  output logic            shutdown_n_out,
  output logic            write_in_progress_out
);
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} dcp_state_type;
  typedef enum logic [1:0] {K_ID, K_ADDR, K_DATA} dcp_kind_type;

  logic [2:0]     scl_s_r, scl_s_nxt, sda_s_r, sda_s_nxt;
  logic           scl_f_r, scl_f_nxt, sda_f_r, sda_f_nxt;
  dcp_state_type  st_r, st_nxt;
  dcp_kind_type   kind_r, kind_nxt;
  logic [3:0]     cnt_r, cnt_nxt;
  logic [7:0]     rx_r, rx_nxt, tx_r, tx_nxt;
  logic [4:0]     ptr_r, ptr_nxt;
  logic           rw_r, rw_nxt, oe_n_r, oe_n_nxt, mack_r, mack_nxt, busy_r, busy_nxt;
  logic           scl_rise, scl_fall, start_seen, stop_seen;
  logic           push, fifo_ready, rec_valid, rec_ready;
  logic [12:0]    rec;
  logic [7:0]     nv_r [dcp_pkg::NV_COUNT];
  logic [7:0]     nv_nxt [dcp_pkg::NV_COUNT];
  logic [7:0]     wiper_r, wiper_nxt;
  logic           vsel_r, vsel_nxt, shdn_r, shdn_nxt;
  logic [dcp_pkg::PROG_CNT_W-1:0] prog_cnt_r, prog_cnt_nxt;
  logic           prog_busy;

  assign prog_busy = (prog_cnt_r != '0);

  // Register value seen by a read at the given pointer.
  function automatic logic [7:0] reg_read(input logic [4:0] a);
    if (a == dcp_pkg::ADDR_INITIAL) begin
      reg_read = vsel_r ? wiper_r : nv_r[0];
    end else if (a == dcp_pkg::ADDR_RESERVED) begin
      reg_read = 8'h00;
    end else if (a < dcp_pkg::ADDR_RESERVED) begin
      reg_read = nv_r[a[3:0]];
    end else if (a == dcp_pkg::ADDR_ACCESS) begin
      reg_read = {vsel_r, shdn_r, prog_busy, 5'h00};
    end else begin
      reg_read = 8'h00;
    end
  endfunction

  // Pointer after one transmitted byte.
  function automatic logic [4:0] ptr_step(input logic [4:0] a);
    ptr_step = (a == dcp_pkg::ADDR_RESERVED) ? 5'h00 : 5'(a + 5'h01);
  endfunction

  always_comb begin
    scl_s_nxt  = {scl_s_r[1:0], scl_in};
    sda_s_nxt  = {sda_s_r[1:0], sda_in};
    scl_f_nxt  = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
    sda_f_nxt  = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
    scl_rise   = ~scl_f_r & scl_f_nxt;
    scl_fall   = scl_f_r & ~scl_f_nxt;
    start_seen = scl_f_r & scl_f_nxt & sda_f_r & ~sda_f_nxt;
    stop_seen  = scl_f_r & scl_f_nxt & ~sda_f_r & sda_f_nxt;
  end

  always_comb begin
    st_nxt   = st_r;
    kind_nxt = kind_r;
    cnt_nxt  = cnt_r;
    rx_nxt   = rx_r;
    tx_nxt   = tx_r;
    ptr_nxt  = ptr_r;
    rw_nxt   = rw_r;
    oe_n_nxt = oe_n_r;
    mack_nxt = mack_r;
    busy_nxt = busy_r;
    push     = 1'b0;
    if (start_seen) begin
      st_nxt   = ST_RX;
      kind_nxt = K_ID;
      cnt_nxt  = 4'h0;
      oe_n_nxt = 1'b1;
      busy_nxt = 1'b1;
    end else if (stop_seen) begin
      st_nxt   = ST_IDLE;
      oe_n_nxt = 1'b1;
      busy_nxt = 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          oe_n_nxt = 1'b1;
        end
        ST_RX: begin
          if (scl_rise) begin
            rx_nxt  = {rx_r[6:0], sda_f_nxt};
            cnt_nxt = 4'(cnt_r + 4'h1);
          end else if (scl_fall && cnt_r == dcp_pkg::BITS_PER_BYTE) begin
            st_nxt   = ST_ACK;
            oe_n_nxt = 1'b0;
            unique case (kind_r)
              K_ID: begin
                if (rx_r[7:1] != {ID_PREFIX, address_select_hi_in, address_select_lo_in}) begin
                  st_nxt   = ST_IDLE;
                  oe_n_nxt = 1'b1;
                end else begin
                  rw_nxt   = rx_r[0];
                  kind_nxt = K_ADDR;
                  if (rx_r[0]) begin
                    tx_nxt  = reg_read(ptr_r);
                    ptr_nxt = ptr_step(ptr_r);
                  end
                end
              end
              K_ADDR: begin
                ptr_nxt  = rx_r[4:0];
                kind_nxt = K_DATA;
              end
              default: begin
                push     = fifo_ready;
                kind_nxt = K_ID;
                if (!fifo_ready) begin
                  st_nxt   = ST_IDLE;
                  oe_n_nxt = 1'b1;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              st_nxt   = ST_TX;
              oe_n_nxt = tx_r[7];
              cnt_nxt  = 4'h1;
            end else if (kind_r == K_ID) begin
              st_nxt   = ST_IDLE;
              oe_n_nxt = 1'b1;
            end else begin
              st_nxt   = ST_RX;
              oe_n_nxt = 1'b1;
              cnt_nxt  = 4'h0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == dcp_pkg::BITS_PER_BYTE) begin
              st_nxt   = ST_MACK;
              oe_n_nxt = 1'b1;
            end else begin
              tx_nxt   = {tx_r[6:0], 1'b0};
              oe_n_nxt = tx_r[6];
              cnt_nxt  = 4'(cnt_r + 4'h1);
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_nxt = ~sda_f_nxt;
          end else if (scl_fall) begin
            if (mack_r) begin
              st_nxt   = ST_TX;
              tx_nxt   = reg_read(ptr_r);
              ptr_nxt  = ptr_step(ptr_r);
              oe_n_nxt = tx_nxt[7];
              cnt_nxt  = 4'h1;
            end else begin
              st_nxt = ST_IDLE;
            end
          end
        end
        default: begin
          st_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      st_r    <= ST_IDLE;
      kind_r  <= K_ID;
      cnt_r   <= 4'h0;
      rx_r    <= 8'h00;
      tx_r    <= 8'h00;
      ptr_r   <= 5'h00;
      rw_r    <= 1'b0;
      oe_n_r  <= 1'b1;
      mack_r  <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      scl_s_r <= scl_s_nxt;
      sda_s_r <= sda_s_nxt;
      scl_f_r <= scl_f_nxt;
      sda_f_r <= sda_f_nxt;
      st_r    <= st_nxt;
      kind_r  <= kind_nxt;
      cnt_r   <= cnt_nxt;
      rx_r    <= rx_nxt;
      tx_r    <= tx_nxt;
      ptr_r   <= ptr_nxt;
      rw_r    <= rw_nxt;
      oe_n_r  <= oe_n_nxt;
      mack_r  <= mack_nxt;
      busy_r  <= busy_nxt;
    end
  end

  dcp_fifo #(
    .WIDTH (dcp_pkg::REC_W),
    .DEPTH (dcp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ready),
    .in_data_in    ({ptr_r, rx_r}),
    .out_valid_out (rec_valid),
    .out_ready_in  (rec_ready),
    .out_data_out  (rec)
  );

  // Records are committed only while the bus is idle after a STOP.
  assign rec_ready = ~busy_r;

  always_comb begin
    nv_nxt    = nv_r;
    wiper_nxt = wiper_r;
    vsel_nxt  = vsel_r;
    shdn_nxt  = shdn_r;
    prog_cnt_nxt = prog_busy ? dcp_pkg::PROG_CNT_W'(prog_cnt_r - 1'b1) : prog_cnt_r;
    if (rec_valid && rec_ready && !prog_busy) begin
      if (rec[12:8] == dcp_pkg::ADDR_INITIAL) begin
        wiper_nxt = rec[7:0];
        if (!vsel_r) begin
          nv_nxt[0]    = rec[7:0];
          prog_cnt_nxt = dcp_pkg::PROG_CNT_W'(NV_WRITE_CYCLES);
        end
      end else if (rec[12:8] < dcp_pkg::ADDR_RESERVED) begin
        nv_nxt[rec[11:8]] = rec[7:0];
        prog_cnt_nxt      = dcp_pkg::PROG_CNT_W'(NV_WRITE_CYCLES);
      end else if (rec[12:8] == dcp_pkg::ADDR_ACCESS) begin
        vsel_nxt = rec[dcp_pkg::VSEL_BIT];
        shdn_nxt = rec[dcp_pkg::SHDN_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < dcp_pkg::NV_COUNT; i++) begin
        nv_r[i] <= (i == 0) ? dcp_pkg::INITIAL_RESET : dcp_pkg::NV_RESET;
      end
      wiper_r <= dcp_pkg::WIPER_RESET;
      vsel_r     <= dcp_pkg::VSEL_RESET;
      shdn_r     <= dcp_pkg::SHDN_RESET;
      prog_cnt_r <= '0;
    end else begin
      nv_r    <= nv_nxt;
      wiper_r <= wiper_nxt;
      vsel_r     <= vsel_nxt;
      shdn_r     <= shdn_nxt;
      prog_cnt_r <= prog_cnt_nxt;
    end
  end

  assign sda_out               = 1'b0;
  assign sda_oe_n_out          = oe_n_r;
  assign wiper_out             = wiper_r;
  assign shutdown_n_out        = shdn_r;
  assign write_in_progress_out = prog_busy;
endmodule // dcp_i2c

// [bench/dcp_i2c_props.sv]
// Concurrent checks on the potentiometer serial slave ports.
`timescale 1ns/10ps
module dcp_i2c_props #(
  parameter int NV_WRITE_CYCLES = 50
) (
  input wire logic       ref_clk_in,
  input wire logic       rst_n_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_oe_n_out,
  input wire logic [7:0] wiper_out,
  input wire logic       shutdown_n_out,
  input wire logic       write_in_progress_out
);
  int busy_cnt_r;
  int busy_cnt_nxt;
  always_comb begin
    busy_cnt_nxt = write_in_progress_out ? busy_cnt_r + 1 : 0;
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) busy_cnt_r <= 0;
    else busy_cnt_r <= busy_cnt_nxt;
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_oe_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
    else $error("data enable changed while clock high");
  chk_ack_after_fall: assert property ($fell(sda_oe_n_out) |-> !$past(scl_in, 2))
    else $error("data pulled low too soon after clock fall");
  chk_stop_release: assert property (scl_in && $past(scl_in) && $rose(sda_in)
    |-> ##1 sda_oe_n_out [*8]) else $error("data driven after stop");
  chk_prog_after_stop: assert property ($rose(write_in_progress_out)
    |-> $past(scl_in, 2) && $past(sda_in, 2)) else $error("programming began mid frame");
  chk_prog_length: assert property ($fell(write_in_progress_out)
    |-> busy_cnt_r >= NV_WRITE_CYCLES && busy_cnt_r <= NV_WRITE_CYCLES + 2)
    else $error("programming time wrong");
  chk_wiper_idle_bus: assert property ($changed(wiper_out)
    |-> $past(scl_in, 2) && $past(sda_in, 2)) else $error("wiper changed mid frame");
  chk_wiper_hold_busy: assert property ($past(write_in_progress_out)
    && write_in_progress_out |-> $stable(wiper_out)) else $error("wiper written while busy");
  chk_shdn_hold_busy: assert property ($past(write_in_progress_out)
    && write_in_progress_out |-> $stable(shutdown_n_out)) else $error("control written busy");
endmodule // dcp_i2c_props
bind dcp_i2c dcp_i2c_props #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) dcp_i2c_props_i (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_oe_n_out(sda_oe_n_out), .wiper_out(wiper_out), .shutdown_n_out(shutdown_n_out),
  .write_in_progress_out(write_in_progress_out));

// [bench/dcp_i2c_master.sv]
// Bus master model driving the serial clock and data lines.
`timescale 1ns/10ps
module dcp_i2c_master (
  // Clock.
  input  wire logic  ref_clk_in,
  // Bus lines; data high means released to the pull-up.
  output logic       scl_out,
  output logic       sda_out,
  input  wire logic  sda_in,
  // Observed results.
  output logic       res_stb_out,
  output logic [7:0] res_data_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    res_stb_out = 1'b0;
    res_data_out = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_out <= b;
    tick(4);
    scl_out <= 1'b1;
    tick(4);
    r = sda_in;
    tick(4);
    scl_out <= 1'b0;
    tick(4);
  endtask
  task automatic post(input logic [7:0] v);
    res_data_out <= v;
    res_stb_out <= 1'b1;
    tick(1);
    res_stb_out <= 1'b0;
  endtask
  task automatic start();
    sda_out <= 1'b1;
    tick(4);
    scl_out <= 1'b1;
    tick(4);
    sda_out <= 1'b0;
    tick(4);
    scl_out <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sda_out <= 1'b0;
    tick(4);
    scl_out <= 1'b1;
    tick(4);
    sda_out <= 1'b1;
    tick(8);
  endtask
  task automatic send(input logic [7:0] v);
    logic r;
    for (int k = 7; k >= 0; k--) bit_io(v[k], r);
    bit_io(1'b1, r);
    post({7'h00, r});
  endtask
  task automatic recv(input logic more);
    logic [7:0] v;
    logic       r;
    for (int k = 0; k < 8; k++) begin
      bit_io(1'b1, r);
      v = {v[6:0], r};
    end
    bit_io(!more, r);
    post(v);
  endtask
endmodule // dcp_i2c_master

// [bench/tb_dcp_i2c.sv]
// Self-checking bench for the potentiometer serial slave.
`timescale 1ns/10ps
module tb_dcp_i2c;
  localparam logic [4:0] PFX = 5'h16;  // Arbitrary address prefix.
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       a_hi = 1'b0;
  logic       a_lo = 1'b0;
  logic       scl;
  logic       sda_m;
  wire logic  sda_w;
  logic       sda_o;
  logic       oe_n;
  logic [7:0] wiper;
  logic       shdn_n;
  logic       prog;
  logic       stb;
  logic [7:0] res;
  logic [7:0] exp_q[$];
  int         mismatches = 0;
  int         checks_done = 0;
  logic [7:0] d;
  logic [7:0] w;
  int         n;
  always #5 clk = ~clk;
  assign sda_w = sda_m & (oe_n | sda_o);
  dcp_i2c #(.NV_WRITE_CYCLES(2000), .ID_PREFIX(PFX)) dcp_i2c_i (
    .ref_clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o),
    .sda_oe_n_out(oe_n), .address_select_hi_in(a_hi), .address_select_lo_in(a_lo),
    .wiper_out(wiper), .shutdown_n_out(shdn_n), .write_in_progress_out(prog));
  dcp_i2c_master dcp_i2c_master_i (
    .ref_clk_in(clk), .scl_out(scl), .sda_out(sda_m), .sda_in(sda_w),
    .res_stb_out(stb), .res_data_out(res));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (stb === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("[ERR] bus result expected none seen %h", res);
      end else begin
        chk("bus result", exp_q.pop_front(), res);
      end
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    repeat (3) exp_q.push_back(8'h00);
    dcp_i2c_master_i.start();
    dcp_i2c_master_i.send({PFX, a_hi, a_lo, 1'b0});
    dcp_i2c_master_i.send(a);
    dcp_i2c_master_i.send(v);
    dcp_i2c_master_i.stop();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e[$]);
    repeat (3) exp_q.push_back(8'h00);
    foreach (e[k]) exp_q.push_back(e[k]);
    dcp_i2c_master_i.start();
    dcp_i2c_master_i.send({PFX, a_hi, a_lo, 1'b0});
    dcp_i2c_master_i.send(a);
    dcp_i2c_master_i.start();
    dcp_i2c_master_i.send({PFX, a_hi, a_lo, 1'b1});
    foreach (e[k]) dcp_i2c_master_i.recv(k < e.size() - 1);
    dcp_i2c_master_i.stop();
  endtask
  task automatic wait_idle();
    n = 0;
    while (prog !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk("busy flag", 8'h00, {7'h00, prog});
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  initial begin
    void'($urandom(32'he2c4ac3f));
    d = 8'($urandom);
    w = 8'($urandom);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    {a_hi, a_lo} <= 2'($urandom);
    repeat (8) @(posedge clk);
    wr(8'h10, 8'h80);
    wr(8'h00, w);
    wr(8'h0E, d);
    wr(8'h00, ~w);
    wait_idle();
    rd(8'h0E, '{d, 8'h00, w});
    rd(8'h10, '{8'h80});
    exp_q.push_back(8'h01);
    dcp_i2c_master_i.start();
    dcp_i2c_master_i.send({PFX, a_hi, ~a_lo, 1'b0});
    dcp_i2c_master_i.stop();
    chk("wiper", w, wiper);
    chk("shutdown", 8'h00, {7'h00, shdn_n});
    wr(8'h10, 8'h40);
    wr(8'h00, ~d);
    chk("busy set", 8'h01, {7'h00, prog});
    wait_idle();
    rd(8'h00, '{~d, 8'h00});
    chk("wiper", ~d, wiper);
    chk("shutdown", 8'h01, {7'h00, shdn_n});
    chk("pending results", 8'h00, 8'(exp_q.size()));
    end_sim();
  end
endmodule // tb_dcp_i2c
